/* rtl/wlo_digit_mask.sv */
// Masks a bit-device operand to its designated digit count
`timescale 1ns/1ps
`include "wlo_map.svh"
module wlo_digit_mask
  import wlo_pkg::*;
(
  input wire logic is_bit,
  input wire logic [`WLO_DIGITS_W-1:0] digits,
  input wire wlo_word_t din,
  output wlo_word_t dout
);
  wire [`WLO_DIGITS_W:0] ndig = {1'b0, digits} + 3'h1;
  genvar g;
  generate
    for (g = 0; g < `WLO_WORD_W / `WLO_DIGIT_W; g++) begin : g_digit
      wire keep = !is_bit || (ndig > 3'(g));
      assign dout[g*`WLO_DIGIT_W +: `WLO_DIGIT_W] =
        keep ? din[g*`WLO_DIGIT_W +: `WLO_DIGIT_W] : 4'h0;
    end
  endgenerate
endmodule // wlo_digit_mask

/* rtl/wlo_map.svh */
// Constants for the word logic operation unit
`ifndef WLO_MAP_SVH
`define WLO_MAP_SVH
`define WLO_WORD_W 16
`define WLO_DIGIT_W 4
`define WLO_DIGITS_W 2
`define WLO_OPC_W 3
`define WLO_OP_AND 3'h0
`define WLO_OP_OR 3'h1
`define WLO_OP_XOR 3'h2
`define WLO_OP_XNOR 3'h3
`define WLO_FORM_TWO 1'h0
`define WLO_FORM_THREE 1'h1
`endif

/* rtl/wlo_pkg.sv */
// Types for the word logic operation unit
`include "wlo_map.svh"
package wlo_pkg;
  typedef logic [`WLO_WORD_W-1:0] wlo_word_t;
  typedef enum logic [`WLO_OPC_W-1:0] {
    WLO_AND = `WLO_OP_AND,
    WLO_OR = `WLO_OP_OR,
    WLO_XOR = `WLO_OP_XOR,
    WLO_XNOR = `WLO_OP_XNOR
  } wlo_op_e;
  typedef struct packed {
    wlo_op_e op;
    logic three_form;
    logic pulse_mode;
    logic s1_is_bit;
    logic [`WLO_DIGITS_W-1:0] s1_digits;
    logic s2_is_bit;
    logic [`WLO_DIGITS_W-1:0] s2_digits;
    wlo_word_t s1;
    wlo_word_t s2;
    wlo_word_t dst;
  } wlo_req_s;
  typedef struct packed {
    logic valid;
    logic err;
    wlo_word_t result;
  } wlo_res_s;
endpackage

/* rtl/wlo_unit.sv */
// Word logic operation unit: AND, OR, XOR, XNOR on 16-bit operands
// Operation
// - Two-operand AND: destination AND source written back to destination.
// - Three-operand AND: first source AND second source into destination.
// - Two-operand OR: destination OR source written back to destination.
// - Three-operand OR: first source OR second source into destination.
// - Three-operand XOR: first source XOR second source into destination.
// - Bit-device operand bits above designated digits count as zero.
// - Three-operand XNOR: bitwise XNOR of both sources into destination.
// - Digit count selects width in 4-bit groups from bit 0, 4 to 16.
`timescale 1ns/1ps
`include "wlo_map.svh"
module wlo_unit
  import wlo_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scan_en,
  input wire logic exec_cond,
  input wire wlo_req_s req,
  output wlo_res_s res_q,
  output logic operation_error_latch_q
);
  wlo_word_t a_m, b_m, s1_m, s2_m, dst_m, res_d;
  logic cond_prev_q;
  // Two-operand form reads the destination as first operand
  wlo_digit_mask u_mask_a (
    .is_bit(req.s1_is_bit),
    .digits(req.s1_digits),
    .din(req.s1),
    .dout(s1_m)
  );
  wlo_digit_mask u_mask_b (
    .is_bit(req.s2_is_bit),
    .digits(req.s2_digits),
    .din(req.s2),
    .dout(s2_m)
  );
  assign dst_m = req.dst;
  assign a_m = req.three_form ? s1_m : dst_m;
  assign b_m = req.three_form ? s2_m : s1_m;
  // XOR/XNOR only exist in three-operand form here; two-operand request flags error
  wire bad_form = !req.three_form && (req.op == WLO_XOR || req.op == WLO_XNOR);
  wire bad_op = !(req.op inside {WLO_AND, WLO_OR, WLO_XOR, WLO_XNOR});
  wire fire = scan_en && exec_cond && (!req.pulse_mode || !cond_prev_q);
  always_comb begin
    case (req.op)
      WLO_AND: res_d = a_m & b_m;
      WLO_OR: res_d = a_m | b_m;
      WLO_XOR: res_d = a_m ^ b_m;
      WLO_XNOR: res_d = ~(a_m ^ b_m);
      default: res_d = '0;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cond_prev_q <= 1'b0;
    end else if (scan_en) begin
      cond_prev_q <= exec_cond;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      res_q <= '0;
    end else begin
      res_q.valid <= fire && !bad_form && !bad_op;
      res_q.err <= fire && (bad_form || bad_op);
      if (fire && !bad_form && !bad_op) begin
        res_q.result <= res_d;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      operation_error_latch_q <= 1'b0;
    end else if (fire && (bad_form || bad_op)) begin
      operation_error_latch_q <= 1'b1;
    end
  end
  chk_and_result: assert property (@(posedge core_clk) disable iff (rst)
    fire && req.op == WLO_AND && !req.three_form |=> res_q.valid
    && res_q.result == ($past(req.dst) & $past(s1_m))) else $error("and result");
  chk_and3_result: assert property (@(posedge core_clk) disable iff (rst)
    fire && req.op == WLO_AND && req.three_form |=> res_q.valid
    && res_q.result == ($past(s1_m) & $past(s2_m))) else $error("and3 result");
  chk_or_result: assert property (@(posedge core_clk) disable iff (rst)
    fire && req.op == WLO_OR && !req.three_form |=>
    res_q.result == ($past(req.dst) | $past(s1_m))) else $error("or result");
  chk_or3_result: assert property (@(posedge core_clk) disable iff (rst)
    fire && req.op == WLO_OR && req.three_form |=>
    res_q.result == ($past(s1_m) | $past(s2_m))) else $error("or3 result");
  chk_xor_result: assert property (@(posedge core_clk) disable iff (rst)
    fire && req.op == WLO_XOR && req.three_form |=>
    res_q.result == ($past(s1_m) ^ $past(s2_m))) else $error("xor result");
  chk_xnor_result: assert property (@(posedge core_clk) disable iff (rst)
    fire && req.op == WLO_XNOR && req.three_form |=>
    res_q.result == ~($past(s1_m) ^ $past(s2_m))) else $error("xnor result");
  chk_digit_zero: assert property (@(posedge core_clk) disable iff (rst)
    req.s1_is_bit && req.s1_digits == 2'h0 |-> s1_m[15:4] == 12'h000
    && s1_m[3:0] == req.s1[3:0]) else $error("digit mask");
  chk_digit_full: assert property (@(posedge core_clk) disable iff (rst)
    req.s2_is_bit && req.s2_digits == 2'h3 |-> s2_m == req.s2)
    else $error("full width mask");
  chk_pulse_once: assert property (@(posedge core_clk) disable iff (rst)
    scan_en && exec_cond && req.pulse_mode && cond_prev_q |=> !res_q.valid && !res_q.err)
    else $error("pulse repeated");
  chk_plain_every: assert property (@(posedge core_clk) disable iff (rst)
    scan_en && exec_cond && !req.pulse_mode && !bad_form && !bad_op |=> res_q.valid)
    else $error("plain missed");
endmodule // wlo_unit

/* tb/test_wlo_unit.sv */
// Self-checking bench for the word logic operation unit
`timescale 1ns/1ps
module test_wlo_unit;
  import wlo_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, scan_en = 1'b0, exec_cond = 1'b0, v, e;
  logic operation_error_latch_q;
  wlo_req_s req = '0;
  wlo_res_s res_q;
  int err_total = 0, tests_run = 0;
  always #12.5 core_clk = ~core_clk;
  wlo_unit i_dut (.core_clk(core_clk), .rst(rst), .scan_en(scan_en), .exec_cond(exec_cond),
    .req(req), .res_q(res_q), .operation_error_latch_q(operation_error_latch_q));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic wlo_req_s mk(wlo_op_e op, logic th, logic pm, logic [15:0] a, b, d);
    return '{op:op, three_form:th, pulse_mode:pm, s1:a, s2:b, dst:d, default:'0};
  endfunction
  // Valid is read 1 ns after the edge that takes the request
  task automatic step(input wlo_req_s r, input logic cond);
    @(posedge core_clk);
    req <= r;
    exec_cond <= cond;
    scan_en <= 1'b1;
    @(posedge core_clk);
    scan_en <= 1'b0;
    #1;
    v = res_q.valid;
    e = res_q.err;
  endtask
  // Two-operand XOR and an undefined code must raise the error, keep the result
  task automatic t_err();
    wlo_req_s r;
    r = mk(WLO_AND, 1'b1, 1'b0, 16'h1111, 16'h1111, 16'h0);
    step(r, 1'b1);
    chk("no err", {15'h0, e}, 16'h0000);
    chk("latch idle", {15'h0, operation_error_latch_q}, 16'h0000);
    r = mk(WLO_XOR, 1'b0, 1'b0, 16'h00ff, 16'h0f0f, 16'h0);
    step(r, 1'b1);
    chk("err two xor", {15'h0, e}, 16'h0001);
    chk("err no valid", {15'h0, v}, 16'h0000);
    chk("result kept", res_q.result, 16'h1111);
    chk("err latch", {15'h0, operation_error_latch_q}, 16'h0001);
    r = mk(WLO_AND, 1'b1, 1'b0, 16'h00ff, 16'h0f0f, 16'h0);
    r.op = wlo_op_e'(3'h5);
    step(r, 1'b1);
    chk("err bad op", {15'h0, e}, 16'h0001);
    chk("bad op kept", res_q.result, 16'h1111);
    $display("t_err done");
  endtask
  task automatic t_three();
    wlo_op_e ops[4] = '{WLO_AND, WLO_OR, WLO_XOR, WLO_XNOR};
    logic [15:0] ex[4] = '{16'h000f, 16'h0fff, 16'h0ff0, 16'hf00f};
    for (int i = 0; i < 4; i++) begin
      step(mk(ops[i], 1'b1, 1'b0, 16'h00ff, 16'h0f0f, 16'h5a5a), 1'b1);
      chk("three valid", {15'h0, v}, 16'h0001);
      chk("three result", res_q.result, ex[i]);
    end
    $display("t_three done");
  endtask
  // Second source is nonzero so a wrong operand pick shows up
  task automatic t_two();
    step(mk(WLO_AND, 1'b0, 1'b0, 16'hff00, 16'h1234, 16'hf0f0), 1'b1);
    chk("and two", res_q.result, 16'hf000);
    step(mk(WLO_OR, 1'b0, 1'b0, 16'hff00, 16'h1234, 16'hf0f0), 1'b1);
    chk("or two", res_q.result, 16'hfff0);
    $display("t_two done");
  endtask
  task automatic t_mask();
    for (int d = 0; d < 4; d++) begin
      step('{op:WLO_OR, three_form:1'b1, s1_is_bit:1'b1, s1_digits:d[1:0], s1:16'hffff,
        default:'0}, 1'b1);
      chk("digit mask", res_q.result, 16'hffff >> (12 - 4 * d));
    end
    $display("t_mask done");
  endtask
  task automatic t_pulse();
    logic c[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    logic pm[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic [15:0] ev[4] = '{16'h0, 16'h1, 16'h0, 16'h1};
    for (int i = 0; i < 4; i++) begin
      step(mk(WLO_AND, 1'b1, pm[i], 16'h00ff, 16'h0f0f, 16'h0), c[i]);
      chk("pulse valid", {15'h0, v}, ev[i]);
    end
    $display("t_pulse done");
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_three();
    t_two();
    t_mask();
    t_pulse();
    t_err();
    end_sim();
  end
endmodule // test_wlo_unit
